// ---- hrs_common.sv ----
`default_nettype none

package hrs_pkg;
  localparam int N_CHIPS = 4;
  localparam int N_SOFT_WORDS = 30;
  localparam logic [9:0] OFS_ATTR = 10'h002;
  localparam logic [9:0] OFS_ATTR_END = 10'h169;
  localparam logic [9:0] OFS_CAPS = 10'h170;
  localparam logic [9:0] OFS_VVER = 10'h182;
  localparam logic [9:0] OFS_COMMIT = 10'h184;
  localparam logic [9:0] OFS_WLTHR = 10'h188;
  localparam logic [9:0] OFS_GBB = 10'h18C;
  localparam logic [9:0] OFS_GWL = 10'h18D;
  localparam logic [9:0] OFS_AVG = 10'h18E;
  localparam logic [9:0] OFS_WLB = 10'h192;
  localparam logic [9:0] OFS_ZERO = 10'h196;
  localparam logic [9:0] OFS_SUM = 10'h1FF;
  localparam logic [9:0] SLOT_BYTES = 10'h00C;
  localparam logic [4:0] SLOT_SOFT_FIRST = 5'h02;
  localparam logic [4:0] SLOT_SOFT_END = 5'h0C;
  localparam logic [15:0] STRUCT_VER = 16'h0010;
  localparam logic [15:0] CAPS_WORD = 16'h0003;
  localparam logic [15:0] CONTENT_VER = 16'h0004;
  localparam logic [15:0] ATTR_FLAGS = 16'h0003;
  localparam logic [7:0] ID_SPARE = 8'hC4;
  localparam logic [7:0] ID_WORST = 8'hD5;
  localparam logic [7:0] PCT_FULL = 8'h64;
  localparam logic [7:0] CMD_SMART = 8'hB0;
  localparam logic [7:0] FEAT_READ = 8'hD0;
  localparam logic [7:0] FEAT_THR = 8'hD1;
  localparam logic [7:0] FEAT_AUTOSAVE = 8'hD2;
  localparam logic [7:0] FEAT_ENA = 8'hD8;
  localparam logic [7:0] FEAT_DIS = 8'hD9;
  localparam logic [7:0] FEAT_STATUS = 8'hDA;
  localparam logic [7:0] SIG_CYL_LO = 8'h4F;
  localparam logic [7:0] SIG_CYL_HI = 8'hC2;
  localparam logic [7:0] A_STATUS = 8'h00;
  localparam logic [7:0] A_SPARE_THR = 8'h04;
  localparam logic [7:0] A_WL_THR = 8'h08;
  localparam logic [7:0] A_COMMIT = 8'h0C;
  localparam logic [7:0] A_AVG_ERASE = 8'h10;
  localparam logic [7:0] A_WL_BLOCKS = 8'h14;
  localparam logic [7:0] A_MAX_ERASE = 8'h18;
  localparam logic [7:0] A_CHIP = 8'h20;
  localparam logic [7:0] A_CHIP_END = 8'h30;
  localparam logic [7:0] A_ATTR = 8'h40;
  localparam logic [7:0] A_ATTR_END = 8'hB8;
  localparam logic [7:0] SPARE_THR_RST = 8'h0A;
  localparam logic [31:0] WL_THR_RST = 32'hFFFF_FFFF;
  localparam logic [31:0] CHIP_RST = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [7:0] command;
    logic [7:0] feature;
    logic [7:0] cyl_lo;
    logic [7:0] cyl_hi;
  } hrs_cmd_t;

  typedef struct packed {
    logic [15:0] cur;
    logic [15:0] init;
  } hrs_chip_t;

  typedef struct packed {
    logic [7:0] pct_min;
    logic [23:0] init_sum;
    logic [23:0] cur_sum;
    logic [15:0] worst_init;
    logic [15:0] worst_cur;
    logic any_empty;
  } hrs_spare_t;
endpackage

module hrs_spare_calc (
  input wire hrs_pkg::hrs_chip_t [hrs_pkg::N_CHIPS-1:0] chips,
  output hrs_pkg::hrs_spare_t spare
);
  logic [7:0] pct [hrs_pkg::N_CHIPS];

  genvar g;
  generate
    for (g = 0; g < hrs_pkg::N_CHIPS; g++) begin : g_pct
      logic [22:0] scaled;
      // a chip with no spares at build time counts as untouched
      assign scaled = (chips[g].init == 16'h0000) ? 23'h000064 :
        (23'(chips[g].cur) * 23'h000064) / 23'(chips[g].init);
      assign pct[g] = (scaled > 23'h000064) ? hrs_pkg::PCT_FULL :
        scaled[7:0];
    end
  endgenerate

  always_comb begin
    spare = '0;
    spare.pct_min = hrs_pkg::PCT_FULL;
    spare.worst_init = chips[0].init;
    spare.worst_cur = chips[0].cur;
    for (int i = 0; i < hrs_pkg::N_CHIPS; i++) begin
      if (pct[i] < spare.pct_min) begin
        spare.pct_min = pct[i];
      end
      spare.init_sum = spare.init_sum + 24'(chips[i].init);
      spare.cur_sum = spare.cur_sum + 24'(chips[i].cur);
      if (chips[i].cur < spare.worst_cur) begin
        spare.worst_init = chips[i].init;
        spare.worst_cur = chips[i].cur;
      end
      if (chips[i].cur == 16'h0000 && chips[i].init != 16'h0000) begin
        spare.any_empty = 1'b1;
      end
    end
  end
endmodule

`default_nettype wire

// ---- hrs_sector_builder.sv ----
// The address map and the AXI4-Lite register port were chosen for this implementation.
`default_nettype none

module hrs_sector_builder (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [7:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [7:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  input wire logic cmd_valid,
  input wire hrs_pkg::hrs_cmd_t cmd,
  output logic cmd_abort,
  output logic stat_valid,
  output logic stat_exceeded,
  output logic out_valid,
  output logic [7:0] out_data,
  output logic out_last,
  input wire logic out_ready
);
  typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_SEND = 2'b01} hrs_st_t;

  hrs_st_t st_ff;
  logic [9:0] idx_ff;
  logic [7:0] sum_ff;
  logic [7:0] nxt_byte;
  logic can_load;
  logic aw_full_ff, w_full_ff, awready_ff, wready_ff, bvalid_ff;
  logic arready_ff, rvalid_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic [31:0] rdata_ff, nxt_rdata;
  logic nxt_rerr, wr_hit;
  logic [7:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic [7:0] spare_thr_ff;
  logic [31:0] wl_thr_ff, commit_ff, avg_ff, wlb_ff, max_erase_ff;
  hrs_pkg::hrs_chip_t [hrs_pkg::N_CHIPS-1:0] chip_ff;
  logic [31:0] soft_ff [hrs_pkg::N_SOFT_WORDS];
  hrs_pkg::hrs_spare_t spare_w, spare_ff;
  logic [7:0] worst_val_ff;
  logic gbb_ff, gwl_ff, abort_ff, stat_v_ff, stat_x_ff;
  logic out_valid_ff, out_last_ff;
  logic [7:0] out_data_ff;
  logic smart_sig, busy, do_wr, aw_take, w_take, ar_take;
  logic [9:0] take_cnt_ff;
  logic [7:0] take_sum_ff;

  function automatic logic [7:0] le_byte(input logic [31:0] w,
                                         input logic [1:0] k);
    logic [31:0] t;
    t = w >> {k, 3'b000};
    return t[7:0];
  endfunction

  function automatic logic [7:0] entry_byte(input logic [7:0] id,
    input logic [7:0] val, input logic [7:0] worst,
    input logic [23:0] raw_a, input logic [23:0] raw_b,
    input logic [3:0] pos);
    logic [7:0] b;
    b = 8'h00;
    case (pos)
      4'h0: b = id;
      4'h1: b = hrs_pkg::ATTR_FLAGS[7:0];
      4'h2: b = hrs_pkg::ATTR_FLAGS[15:8];
      4'h3: b = val;
      4'h4: b = worst;
      4'h5, 4'h6, 4'h7: b = le_byte({8'h00, raw_a}, 2'(pos - 4'h5));
      4'h8, 4'h9, 4'hA: b = le_byte({8'h00, raw_b}, 2'(pos - 4'h8));
      default: b = 8'h00;
    endcase
    return b;
  endfunction

  function automatic logic [31:0] strb_merge(input logic [31:0] old,
    input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction

  hrs_spare_calc u_calc (
    .chips(chip_ff),
    .spare(spare_w)
  );

  // registered so the wide divider does not sit on the byte path
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      spare_ff <= '0;
      worst_val_ff <= hrs_pkg::PCT_FULL;
      gbb_ff <= 1'b0;
      gwl_ff <= 1'b0;
    end else begin
      spare_ff <= spare_w;
      if (spare_w.pct_min < worst_val_ff) begin
        worst_val_ff <= spare_w.pct_min;
      end
      if (spare_w.any_empty) begin
        gbb_ff <= 1'b1;
      end
      if (max_erase_ff >= wl_thr_ff) begin
        gwl_ff <= 1'b1;
      end
    end
  end

  // byte at the current sector offset
  always_comb begin
    logic [9:0] rel, slot, pos;
    logic [4:0] widx;
    rel = idx_ff - hrs_pkg::OFS_ATTR;
    slot = rel / hrs_pkg::SLOT_BYTES;
    pos = rel - 10'(slot * hrs_pkg::SLOT_BYTES);
    widx = 5'(10'(slot - 10'(hrs_pkg::SLOT_SOFT_FIRST)) * 10'h003
      + (pos >> 2));
    nxt_byte = 8'h00;
    if (idx_ff < hrs_pkg::OFS_ATTR) begin
      nxt_byte = le_byte({16'h0000, hrs_pkg::STRUCT_VER}, idx_ff[1:0]);
    end else if (idx_ff <= hrs_pkg::OFS_ATTR_END) begin
      if (slot == 10'h000) begin
        nxt_byte = entry_byte(hrs_pkg::ID_SPARE, spare_ff.pct_min,
          worst_val_ff, spare_ff.init_sum, spare_ff.cur_sum, pos[3:0]);
      end else if (slot == 10'h001) begin
        nxt_byte = entry_byte(hrs_pkg::ID_WORST, hrs_pkg::PCT_FULL,
          hrs_pkg::PCT_FULL, {8'h00, spare_ff.worst_init},
          {8'h00, spare_ff.worst_cur}, pos[3:0]);
      end else if (slot < 10'(hrs_pkg::SLOT_SOFT_END) && pos != 10'h00B) begin
        nxt_byte = le_byte(soft_ff[widx], pos[1:0]);
      end else begin
        nxt_byte = 8'h00;
      end
    end else if (idx_ff == hrs_pkg::OFS_CAPS ||
                 idx_ff == hrs_pkg::OFS_CAPS + 10'h001) begin
      nxt_byte = le_byte({16'h0000, hrs_pkg::CAPS_WORD}, idx_ff[1:0]);
    end else if (idx_ff == hrs_pkg::OFS_VVER ||
                 idx_ff == hrs_pkg::OFS_VVER + 10'h001) begin
      nxt_byte = le_byte({16'h0000, hrs_pkg::CONTENT_VER},
        2'(idx_ff - hrs_pkg::OFS_VVER));
    end else if (idx_ff >= hrs_pkg::OFS_COMMIT && idx_ff < hrs_pkg::OFS_WLTHR) begin
      nxt_byte = le_byte(commit_ff, idx_ff[1:0]);
    end else if (idx_ff >= hrs_pkg::OFS_WLTHR && idx_ff < hrs_pkg::OFS_GBB) begin
      nxt_byte = le_byte(wl_thr_ff, idx_ff[1:0]);
    end else if (idx_ff == hrs_pkg::OFS_GBB) begin
      nxt_byte = {7'h00, gbb_ff};
    end else if (idx_ff == hrs_pkg::OFS_GWL) begin
      nxt_byte = {7'h00, gwl_ff};
    end else if (idx_ff >= hrs_pkg::OFS_AVG && idx_ff < hrs_pkg::OFS_WLB) begin
      nxt_byte = le_byte(avg_ff, 2'(idx_ff - hrs_pkg::OFS_AVG));
    end else if (idx_ff >= hrs_pkg::OFS_WLB && idx_ff < hrs_pkg::OFS_ZERO) begin
      nxt_byte = le_byte(wlb_ff, 2'(idx_ff - hrs_pkg::OFS_WLB));
    end else if (idx_ff == hrs_pkg::OFS_SUM) begin
      nxt_byte = 8'h00 - sum_ff;
    end
  end

  assign smart_sig = cmd.command == hrs_pkg::CMD_SMART &&
    cmd.cyl_lo == hrs_pkg::SIG_CYL_LO && cmd.cyl_hi == hrs_pkg::SIG_CYL_HI;
  assign busy = st_ff == ST_SEND || out_valid_ff;
  assign can_load = st_ff == ST_SEND && (!out_valid_ff || out_ready);

  // a read-data request arriving while a sector is still going out aborts
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= ST_IDLE;
      idx_ff <= 10'h000;
      sum_ff <= 8'h00;
      abort_ff <= 1'b0;
      stat_v_ff <= 1'b0;
      stat_x_ff <= 1'b0;
    end else begin
      abort_ff <= 1'b0;
      stat_v_ff <= 1'b0;
      if (cmd_valid && cmd.command == hrs_pkg::CMD_SMART) begin
        if (smart_sig && cmd.feature == hrs_pkg::FEAT_READ && !busy) begin
          st_ff <= ST_SEND;
          idx_ff <= 10'h000;
          sum_ff <= 8'h00;
        end else if (smart_sig && cmd.feature == hrs_pkg::FEAT_STATUS) begin
          stat_v_ff <= 1'b1;
          stat_x_ff <= spare_ff.pct_min < spare_thr_ff;
        end else if (!(smart_sig && (cmd.feature == hrs_pkg::FEAT_THR ||
            cmd.feature == hrs_pkg::FEAT_AUTOSAVE ||
            cmd.feature == hrs_pkg::FEAT_ENA ||
            cmd.feature == hrs_pkg::FEAT_DIS))) begin
          abort_ff <= 1'b1;
        end
      end
      if (can_load) begin
        idx_ff <= idx_ff + 10'h001;
        sum_ff <= sum_ff + nxt_byte;
        if (idx_ff == hrs_pkg::OFS_SUM) begin
          st_ff <= ST_IDLE;
        end
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      out_valid_ff <= 1'b0;
      out_data_ff <= 8'h00;
      out_last_ff <= 1'b0;
    end else if (can_load) begin
      out_valid_ff <= 1'b1;
      out_data_ff <= nxt_byte;
      out_last_ff <= idx_ff == hrs_pkg::OFS_SUM;
    end else if (out_ready) begin
      out_valid_ff <= 1'b0;
      out_last_ff <= 1'b0;
    end
  end

  assign aw_take = s_awvalid && awready_ff;
  assign w_take = s_wvalid && wready_ff;
  assign do_wr = aw_full_ff && w_full_ff && !bvalid_ff;
  assign ar_take = s_arvalid && arready_ff;
  assign wr_hit = awaddr_ff <= hrs_pkg::A_MAX_ERASE ||
    (awaddr_ff >= hrs_pkg::A_CHIP && awaddr_ff < hrs_pkg::A_CHIP_END) ||
    (awaddr_ff >= hrs_pkg::A_ATTR && awaddr_ff < hrs_pkg::A_ATTR_END);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_full_ff <= 1'b0;
      w_full_ff <= 1'b0;
      awready_ff <= 1'b0;
      wready_ff <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff <= hrs_pkg::RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_full_ff <= 1'b1;
        awaddr_ff <= {s_awaddr[7:2], 2'b00};
      end else if (do_wr) begin
        aw_full_ff <= 1'b0;
      end
      if (w_take) begin
        w_full_ff <= 1'b1;
        wdata_ff <= s_wdata;
        wstrb_ff <= s_wstrb;
      end else if (do_wr) begin
        w_full_ff <= 1'b0;
      end
      awready_ff <= !(aw_take || (aw_full_ff && !do_wr));
      wready_ff <= !(w_take || (w_full_ff && !do_wr));
      if (do_wr) begin
        bvalid_ff <= 1'b1;
        bresp_ff <= wr_hit ? hrs_pkg::RESP_OKAY : hrs_pkg::RESP_SLVERR;
      end else if (s_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // status word is read-only; a write to it answers okay and is dropped
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      spare_thr_ff <= hrs_pkg::SPARE_THR_RST;
      wl_thr_ff <= hrs_pkg::WL_THR_RST;
      commit_ff <= 32'h0000_0000;
      avg_ff <= 32'h0000_0000;
      wlb_ff <= 32'h0000_0000;
      max_erase_ff <= 32'h0000_0000;
      chip_ff <= '0;
      for (int i = 0; i < hrs_pkg::N_SOFT_WORDS; i++) begin
        soft_ff[i] <= 32'h0000_0000;
      end
    end else if (do_wr) begin
      if (awaddr_ff == hrs_pkg::A_SPARE_THR) begin
        spare_thr_ff <= 8'(strb_merge({24'h000000, spare_thr_ff},
          wdata_ff, wstrb_ff));
      end else if (awaddr_ff == hrs_pkg::A_WL_THR) begin
        wl_thr_ff <= strb_merge(wl_thr_ff, wdata_ff, wstrb_ff);
      end else if (awaddr_ff == hrs_pkg::A_COMMIT) begin
        commit_ff <= strb_merge(commit_ff, wdata_ff, wstrb_ff);
      end else if (awaddr_ff == hrs_pkg::A_AVG_ERASE) begin
        avg_ff <= strb_merge(avg_ff, wdata_ff, wstrb_ff);
      end else if (awaddr_ff == hrs_pkg::A_WL_BLOCKS) begin
        wlb_ff <= strb_merge(wlb_ff, wdata_ff, wstrb_ff);
      end else if (awaddr_ff == hrs_pkg::A_MAX_ERASE) begin
        max_erase_ff <= strb_merge(max_erase_ff, wdata_ff, wstrb_ff);
      end else if (awaddr_ff >= hrs_pkg::A_CHIP &&
                   awaddr_ff < hrs_pkg::A_CHIP_END) begin
        chip_ff[awaddr_ff[3:2]] <= strb_merge(chip_ff[awaddr_ff[3:2]],
          wdata_ff, wstrb_ff);
      end else if (awaddr_ff >= hrs_pkg::A_ATTR &&
                   awaddr_ff < hrs_pkg::A_ATTR_END) begin
        soft_ff[5'(8'(awaddr_ff - hrs_pkg::A_ATTR) >> 2)] <= strb_merge(
          soft_ff[5'(8'(awaddr_ff - hrs_pkg::A_ATTR) >> 2)], wdata_ff,
          wstrb_ff);
      end
    end
  end

  always_comb begin
    logic [7:0] a;
    a = {s_araddr[7:2], 2'b00};
    nxt_rdata = 32'h0000_0000;
    nxt_rerr = 1'b0;
    if (a == hrs_pkg::A_STATUS) begin
      nxt_rdata = {8'h00, worst_val_ff, spare_ff.pct_min, 4'h0,
        spare_ff.pct_min < spare_thr_ff, gwl_ff, gbb_ff, busy};
    end else if (a == hrs_pkg::A_SPARE_THR) begin
      nxt_rdata = {24'h000000, spare_thr_ff};
    end else if (a == hrs_pkg::A_WL_THR) begin
      nxt_rdata = wl_thr_ff;
    end else if (a == hrs_pkg::A_COMMIT) begin
      nxt_rdata = commit_ff;
    end else if (a == hrs_pkg::A_AVG_ERASE) begin
      nxt_rdata = avg_ff;
    end else if (a == hrs_pkg::A_WL_BLOCKS) begin
      nxt_rdata = wlb_ff;
    end else if (a == hrs_pkg::A_MAX_ERASE) begin
      nxt_rdata = max_erase_ff;
    end else if (a >= hrs_pkg::A_CHIP && a < hrs_pkg::A_CHIP_END) begin
      nxt_rdata = chip_ff[a[3:2]];
    end else if (a >= hrs_pkg::A_ATTR && a < hrs_pkg::A_ATTR_END) begin
      nxt_rdata = soft_ff[5'(8'(a - hrs_pkg::A_ATTR) >> 2)];
    end else begin
      nxt_rerr = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= hrs_pkg::RESP_OKAY;
    end else if (ar_take) begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b1;
      rdata_ff <= nxt_rdata;
      rresp_ff <= nxt_rerr ? hrs_pkg::RESP_SLVERR : hrs_pkg::RESP_OKAY;
    end else if (rvalid_ff && s_rready) begin
      rvalid_ff <= 1'b0;
      arready_ff <= 1'b1;
    end else if (!rvalid_ff) begin
      arready_ff <= 1'b1;
    end
  end

  // checker helpers: bytes and byte sum seen by the host
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      take_cnt_ff <= 10'h000;
      take_sum_ff <= 8'h00;
    end else if (out_valid_ff && out_ready) begin
      take_cnt_ff <= out_last_ff ? 10'h000 : take_cnt_ff + 10'h001;
      take_sum_ff <= out_last_ff ? 8'h00 : take_sum_ff + out_data_ff;
    end
  end

  chk_sector_len: assert property (@(posedge ref_clk) disable iff (!rst_n)
    out_valid_ff && out_ready && out_last_ff |-> take_cnt_ff == 10'h1FF)
    else $error("sector length is not 512 bytes");
  chk_sum_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
    out_valid_ff && out_ready && out_last_ff |->
    8'(take_sum_ff + out_data_ff) == 8'h00)
    else $error("sector checksum is not zero");
  chk_version_lo: assert property (@(posedge ref_clk) disable iff (!rst_n)
    can_load && idx_ff == 10'h000 |=> out_data_ff == 8'h10)
    else $error("structure version low byte wrong");
  chk_caps_low: assert property (@(posedge ref_clk) disable iff (!rst_n)
    can_load && idx_ff == 10'h170 |=> out_data_ff == 8'h03 && !out_last_ff)
    else $error("capabilities low byte wrong");
  chk_content_ver: assert property (@(posedge ref_clk) disable iff (!rst_n)
    can_load && idx_ff == 10'h182 ##1 can_load |=> out_data_ff == 8'h00)
    else $error("content version high byte wrong");
  chk_tail_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
    can_load && idx_ff >= 10'h196 && idx_ff < 10'h1FF |=> out_data_ff == 8'h00)
    else $error("tail byte not zero");
  chk_unused_slot: assert property (@(posedge ref_clk) disable iff (!rst_n)
    can_load && idx_ff >= 10'h092 && idx_ff <= 10'h169 |=> out_data_ff == 8'h00)
    else $error("unused attribute slot not zero");
  chk_worst_fixed: assert property (@(posedge ref_clk) disable iff (!rst_n)
    can_load && (idx_ff == 10'h011 || idx_ff == 10'h012) |=> out_data_ff == 8'h64)
    else $error("worst chip value not fixed");
  chk_status_thr: assert property (@(posedge ref_clk) disable iff (!rst_n)
    stat_v_ff |-> stat_x_ff == ($past(spare_ff.pct_min) < $past(spare_thr_ff)))
    else $error("status threshold answer wrong");
  chk_gbb_sticky: assert property (@(posedge ref_clk) disable iff (!rst_n)
    gbb_ff |=> gbb_ff)
    else $error("global bad block flag dropped");

  assign s_awready = awready_ff;
  assign s_wready = wready_ff;
  assign s_bvalid = bvalid_ff;
  assign s_bresp = bresp_ff;
  assign s_arready = arready_ff;
  assign s_rvalid = rvalid_ff;
  assign s_rdata = rdata_ff;
  assign s_rresp = rresp_ff;
  assign cmd_abort = abort_ff;
  assign stat_valid = stat_v_ff;
  assign stat_exceeded = stat_x_ff;
  assign out_valid = out_valid_ff;
  assign out_data = out_data_ff;
  assign out_last = out_last_ff;
endmodule

`default_nettype wire

// ---- hrs_host_sink.sv ----
`default_nettype none
module hrs_host_sink (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic slow,
  input wire logic out_valid,
  input wire logic [7:0] out_data,
  input wire logic out_last,
  output logic out_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [512];
  int cnt = 0;
  int last_at = 0;
  logic [1:0] ph_ff;
  // slow host takes one byte in three, so the hold gets tested
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ph_ff <= 2'h0;
      out_ready <= 1'b0;
    end else begin
      ph_ff <= (ph_ff == 2'h2) ? 2'h0 : ph_ff + 2'h1;
      out_ready <= !slow || ph_ff == 2'h2;
    end
  end
  // no cap on the count, so a 513th byte shows up
  always @(posedge ref_clk) begin
    if (out_valid && out_ready) begin
      mem[cnt] = out_data;
      if (out_last) last_at = cnt;
      cnt = cnt + 1;
    end
  end
endmodule
`default_nettype wire

// ---- tb_hrs_sector_builder.sv ----
`default_nettype none
module tb_hrs_sector_builder;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk, rst_n, awv, wv, bready, arv, rready, cmd_valid, slow;
  logic awready, wready, bvalid, arready, rvalid, cmd_abort, stat_valid;
  logic stat_exc, out_valid, out_last, out_ready, ab, st;
  logic [1:0] bresp, rresp;
  logic [7:0] awaddr, araddr, out_data;
  logic [31:0] wdata, rdata, rd;
  logic [7:0] exp_b [512] = '{default: 8'h00};
  logic [7:0] sum;
  logic [7:0] fl [5] = '{8'hD1, 8'hD2, 8'hD8, 8'hD9, 8'hD3};
  hrs_pkg::hrs_cmd_t cmd;
  int fails = 0;
  int checks_done = 0;
  hrs_sector_builder DUT (.ref_clk(ref_clk), .rst_n(rst_n),
    .s_awaddr(awaddr), .s_awvalid(awv), .s_awready(awready),
    .s_wdata(wdata), .s_wstrb(4'hF), .s_wvalid(wv), .s_wready(wready),
    .s_bresp(bresp), .s_bvalid(bvalid), .s_bready(bready),
    .s_araddr(araddr), .s_arvalid(arv), .s_arready(arready),
    .s_rdata(rdata), .s_rresp(rresp), .s_rvalid(rvalid), .s_rready(rready),
    .cmd_valid(cmd_valid), .cmd(cmd), .cmd_abort(cmd_abort),
    .stat_valid(stat_valid), .stat_exceeded(stat_exc),
    .out_valid(out_valid), .out_data(out_data), .out_last(out_last),
    .out_ready(out_ready));
  hrs_host_sink sink (.ref_clk(ref_clk), .rst_n(rst_n), .slow(slow),
    .out_valid(out_valid), .out_data(out_data), .out_last(out_last),
    .out_ready(out_ready));
  task automatic summarize();
    if (fails == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    logic ad, wd;
    ad = 0;
    wd = 0;
    @(posedge ref_clk);
    awaddr <= a;
    wdata <= d;
    awv <= 1;
    wv <= 1;
    bready <= 1;
    do begin
      @(posedge ref_clk);
      ad |= awready & awv;
      wd |= wready & wv;
      if (ad) awv <= 0;
      if (wd) wv <= 0;
    end while (!(ad && wd));
    do @(posedge ref_clk); while (!bvalid);
    bready <= 0;
  endtask
  task automatic axr(input logic [7:0] a);
    @(posedge ref_clk);
    araddr <= a;
    arv <= 1;
    rready <= 1;
    do @(posedge ref_clk); while (!arready);
    arv <= 0;
    do @(posedge ref_clk); while (!rvalid);
    rready <= 0;
    rd = rdata;
  endtask
  // pulses are gathered over three edges: sampled before each update
  task automatic cmdx(input logic [7:0] f,
    input logic [7:0] lo = hrs_pkg::SIG_CYL_LO);
    cmd <= {hrs_pkg::CMD_SMART, f, lo, hrs_pkg::SIG_CYL_HI};
    cmd_valid <= 1;
    @(posedge ref_clk);
    cmd_valid <= 0;
    ab = 0;
    st = 0;
    repeat (3) begin
      @(posedge ref_clk);
      ab |= cmd_abort;
      st |= stat_valid;
    end
  endtask
  task automatic le(input int o, input logic [31:0] v, input int n);
    for (int i = 0; i < n; i++) exp_b[o + i] = v[8 * i +: 8];
  endtask
  task automatic sector(input logic sl, input logic dbl);
    slow <= sl;
    sink.cnt = 0;
    cmdx(hrs_pkg::FEAT_READ);
    chk("read_abort", 0, ab);
    if (dbl) cmdx(hrs_pkg::FEAT_READ);
    if (dbl) chk("busy_abort", 1, ab);
    wait (sink.cnt == 512);
    repeat (4) @(posedge ref_clk);
    chk("count", 512, sink.cnt);
    chk("last", 511, sink.last_at);
    for (int i = 0; i < 512; i++)
      chk($sformatf("byte%0d", i), exp_b[i], sink.mem[i]);
  endtask
  initial begin
    ref_clk = 0;
    forever #25 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    fails++;
    summarize();
  end
  initial begin
    {rst_n, awv, wv, bready, arv, rready, cmd_valid, slow} = '0;
    {awaddr, araddr, wdata, cmd} = '0;
    repeat (4) @(posedge ref_clk);
    rst_n <= 1;
    repeat (2) @(posedge ref_clk);
    axr(8'hFC);
    chk("rresp", hrs_pkg::RESP_SLVERR, rresp);
    axw(8'hFC, 32'h1);
    chk("bresp", hrs_pkg::RESP_SLVERR, bresp);
    axw(hrs_pkg::A_CHIP, 32'h0032_0064);
    for (int c = 1; c < 4; c++) axw(hrs_pkg::A_CHIP + 8'(4 * c), 32'h0064_0064);
    axw(hrs_pkg::A_COMMIT, 32'hA5);
    axw(hrs_pkg::A_AVG_ERASE, 32'h1234_5678);
    axw(hrs_pkg::A_WL_BLOCKS, 32'h0102);
    axw(hrs_pkg::A_MAX_ERASE, 32'h0);
    le(0, hrs_pkg::STRUCT_VER, 2);
    le(2, {hrs_pkg::ATTR_FLAGS, hrs_pkg::ID_SPARE}, 3);
    le(5, 32'h3232, 2);
    le(7, 32'h190, 3);
    le(10, 32'h15E, 3);
    le(14, {hrs_pkg::ATTR_FLAGS, hrs_pkg::ID_WORST}, 3);
    le(17, {hrs_pkg::PCT_FULL, hrs_pkg::PCT_FULL}, 2);
    le(19, 32'h64, 3);
    le(22, 32'h32, 3);
    le(368, hrs_pkg::CAPS_WORD, 3);
    le(386, hrs_pkg::CONTENT_VER, 2);
    le(388, 32'hA5, 4);
    le(392, hrs_pkg::WL_THR_RST, 4);
    le(398, 32'h1234_5678, 4);
    le(402, 32'h0102, 4);
    sum = 0;
    for (int i = 0; i < 511; i++) sum -= exp_b[i];
    exp_b[511] = sum;
    sector(1, 1);
    // threshold equal to the value is not exceeded, one above it is
    for (int t = 0; t < 2; t++) begin
      axw(hrs_pkg::A_SPARE_THR, 32'h32 + t);
      cmdx(hrs_pkg::FEAT_STATUS);
      chk("stat_valid", 1, st);
      chk("exceeded", t, stat_exc);
    end
    foreach (fl[i]) begin
      cmdx(fl[i]);
      chk("abort", fl[i] == 8'hD3, ab);
    end
    // wrong signature must abort and start no sector
    cmdx(hrs_pkg::FEAT_READ, 8'h00);
    chk("sig_abort", 1, ab);
    sector(0, 0);
    axw(hrs_pkg::A_CHIP + 8'h04, 32'h0000_0064);
    axw(hrs_pkg::A_WL_THR, 32'h5);
    axw(hrs_pkg::A_MAX_ERASE, 32'h5);
    axr(hrs_pkg::A_STATUS);
    chk("global_bb", 1, rd[1]);
    chk("global_wl", 1, rd[2]);
    chk("status", 32'h0000_000E, rd);
    summarize();
  end
endmodule
`default_nettype wire
